// >>> pkg/uie_regs.svh
// Register offsets, field positions, reset values and interrupt codes
`ifndef UIE_REGS_SVH
`define UIE_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define UIE_OFF_HOLDING 4'h0
`define UIE_OFF_ENABLE 4'h1
`define UIE_OFF_IDENT 4'h2

// ****************************************
// Reset values
// ****************************************
`define UIE_RST_ENABLE 8'h00
`define UIE_RST_IDENT 8'h01
`define UIE_RST_DIVISOR 8'h00

// ****************************************
// Enable register fields
// ****************************************
`define UIE_EN_RXDATA 0
`define UIE_EN_THR 1
`define UIE_EN_LINE 2
`define UIE_EN_MODEM 3
`define UIE_EN_SLEEP 4
`define UIE_EN_SWFLOW 5
`define UIE_EN_RTS 6
`define UIE_EN_CTS 7
`define UIE_EN_HI_MASK 8'hF0
`define UIE_EN_LO_MASK 8'h0F

// ****************************************
// Identification codes, bits 5..0
// ****************************************
`define UIE_ID_LINE 6'h06
`define UIE_ID_RXTO 6'h0C
`define UIE_ID_RXDATA 6'h04
`define UIE_ID_THR 6'h02
`define UIE_ID_MODEM 6'h00
`define UIE_ID_PIN 6'h30
`define UIE_ID_SWFLOW 6'h10
`define UIE_ID_FLOWCHG 6'h20

// ****************************************
// Source indices, best priority first
// ****************************************
`define UIE_SRC_LINE 0
`define UIE_SRC_RXTO 1
`define UIE_SRC_RXDATA 2
`define UIE_SRC_THR 3
`define UIE_SRC_MODEM 4
`define UIE_SRC_PIN 5
`define UIE_SRC_SWFLOW 6
`define UIE_SRC_CTS 7
`define UIE_SRC_RTS 8
`define UIE_NSRC 9

`endif

// >>> pkg/uie_pkg.sv
// Types shared by the interrupt enable and identification block
package uie_pkg;
  typedef enum logic [0:0] {
    UIE_AWAKE = 1'b0,
    UIE_ASLEEP = 1'b1
  } uie_sleep_t;
endpackage

// >>> core/uie_prio.sv
// Fixed priority selection of the reported interrupt source
`timescale 1ns/10ps
`include "uie_regs.svh"
module uie_prio #(
  parameter int NSRC = `UIE_NSRC
) (
  // Gated sources, index 0 best
  input wire logic [NSRC-1:0] active,
  // Selection
  output logic pending,
  output logic [5:0] code
);

  function automatic logic [5:0] uie_src_code(input int idx);
    logic [5:0] c;
    c = `UIE_ID_MODEM;
    case (idx)
      `UIE_SRC_LINE: c = `UIE_ID_LINE;
      `UIE_SRC_RXTO: c = `UIE_ID_RXTO;
      `UIE_SRC_RXDATA: c = `UIE_ID_RXDATA;
      `UIE_SRC_THR: c = `UIE_ID_THR;
      `UIE_SRC_PIN: c = `UIE_ID_PIN;
      `UIE_SRC_SWFLOW: c = `UIE_ID_SWFLOW;
      `UIE_SRC_CTS, `UIE_SRC_RTS: c = `UIE_ID_FLOWCHG;
      default: c = `UIE_ID_MODEM;
    endcase
    return c;
  endfunction

  always_comb begin
    pending = 1'b0;
    code = `UIE_ID_MODEM;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (active[i]) begin
        pending = 1'b1;
        code = uie_src_code(i);
      end
    end
  end

endmodule // uie_prio

// >>> core/uie_sleep.sv
// Sleep entry and wake control for crystal and UART clock
`timescale 1ns/10ps
`include "uie_regs.svh"
module uie_sleep (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Conditions
  input wire logic permit,
  input wire logic pending,
  input wire logic modem_toggle,
  input wire logic rx_pin,
  input wire logic tx_fifo_empty,
  input wire logic rx_fifo_empty,
  input wire logic tx_load,
  // Clock controls
  output logic asleep,
  output logic xtal_en,
  output logic uart_clk_en
);

  uie_pkg::uie_sleep_t state_q, state_d;
  logic enter, wake;

  assign enter = permit && !pending && !modem_toggle && rx_pin && tx_fifo_empty && rx_fifo_empty;
  // any wake event, or permission withdrawn
  assign wake = modem_toggle || !rx_pin || tx_load || !permit;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      uie_pkg::UIE_AWAKE: begin
        if (enter) begin
          state_d = uie_pkg::UIE_ASLEEP;
        end
      end
      uie_pkg::UIE_ASLEEP: begin
        if (wake) begin
          state_d = uie_pkg::UIE_AWAKE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= uie_pkg::UIE_AWAKE;
    end else begin
      state_q <= state_d;
    end
  end

  assign asleep = (state_q == uie_pkg::UIE_ASLEEP);
  assign xtal_en = !asleep;
  assign uart_clk_en = !asleep;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_SLEEP_WAKE: assert property (asleep && tx_load |=> !asleep)
    else $error("did not wake on transmit load");
  AST_SLEEP_ENTER: assert property ($rose(asleep) |-> $past(enter))
    else $error("entered sleep without idle conditions");

endmodule // uie_sleep

// >>> core/uie_top.sv
// Interrupt enable, identification, sleep control and divisor high byte of one UART channel
`timescale 1ns/10ps
`include "uie_regs.svh"
module uie_top #(
  parameter int FIFO_DEPTH = 64,
  parameter int LW = $clog2(FIFO_DEPTH + 1)
) (
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic nrst,
  // Software reset, one cycle
  input wire logic sw_reset,
  // Register access port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Configuration from neighbouring registers
  input wire logic divisor_access,
  input wire logic enhanced_en,
  input wire logic fifo_en,
  input wire logic [LW-1:0] tx_trigger,
  // Level sources
  input wire logic line_error,
  input wire logic rx_timeout,
  input wire logic rx_data_ready,
  input wire logic thr_empty,
  input wire logic [LW-1:0] tx_space,
  input wire logic modem_change,
  // Event pulses
  input wire logic pin_change,
  input wire logic xoff_det,
  input wire logic xon_det,
  input wire logic special_det,
  input wire logic cts_inactive,
  input wire logic rts_inactive,
  // Sleep conditions
  input wire logic modem_toggle,
  input wire logic rx_pin,
  input wire logic tx_fifo_empty,
  input wire logic rx_fifo_empty,
  // Outputs
  output logic irq,
  output logic [7:0] interrupt_enable,
  output logic [7:0] baud_divisor_high,
  output logic asleep,
  output logic xtal_en,
  output logic uart_clk_en
);

  // ****************************************
  // Access decode
  // ****************************************
  logic [7:0] enable_q, enable_d;
  logic [7:0] divisor_q, divisor_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] ident_q, ident_d;
  logic irq_q, irq_d;
  logic pin_q, pin_d;
  logic xoff_q, xoff_d;
  logic spec_q, spec_d;
  logic cts_q, cts_d;
  logic rts_q, rts_d;
  logic asleep_q, asleep_d;
  logic xtal_q, xtal_d;
  logic uclk_q, uclk_d;
  logic wr_enable, wr_divisor, rd_ident, tx_load, sleep_permit, tx_ready;
  logic [`UIE_NSRC-1:0] raw_src, active_src;
  logic pend;
  logic [5:0] code;
  logic sl_asleep, sl_xtal, sl_uclk;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off, input logic dl);
    return (a == off) && (dl == 1'b0);
  endfunction

  assign wr_enable = reg_wr && hit(reg_addr, `UIE_OFF_ENABLE, divisor_access);
  assign rd_ident = reg_rd && hit(reg_addr, `UIE_OFF_IDENT, divisor_access);
  assign tx_load = reg_wr && hit(reg_addr, `UIE_OFF_HOLDING, divisor_access);
  assign wr_divisor = reg_wr && (reg_addr == `UIE_OFF_ENABLE) && divisor_access;

  // ****************************************
  // Source gating
  // ****************************************
  // transmit ready in either mode
  assign tx_ready = fifo_en ? (tx_space > tx_trigger) : thr_empty;

  assign raw_src[`UIE_SRC_LINE] = line_error;
  assign raw_src[`UIE_SRC_RXTO] = rx_timeout;
  assign raw_src[`UIE_SRC_RXDATA] = rx_data_ready;
  assign raw_src[`UIE_SRC_THR] = tx_ready;
  assign raw_src[`UIE_SRC_MODEM] = modem_change;
  assign raw_src[`UIE_SRC_PIN] = pin_q;
  assign raw_src[`UIE_SRC_SWFLOW] = xoff_q || spec_q;
  assign raw_src[`UIE_SRC_CTS] = cts_q;
  assign raw_src[`UIE_SRC_RTS] = rts_q;

  assign active_src[`UIE_SRC_LINE] = raw_src[`UIE_SRC_LINE] && enable_q[`UIE_EN_LINE];
  assign active_src[`UIE_SRC_RXTO] = raw_src[`UIE_SRC_RXTO] && enable_q[`UIE_EN_RXDATA];
  assign active_src[`UIE_SRC_RXDATA] = raw_src[`UIE_SRC_RXDATA] && enable_q[`UIE_EN_RXDATA];
  assign active_src[`UIE_SRC_THR] = raw_src[`UIE_SRC_THR] && enable_q[`UIE_EN_THR];
  assign active_src[`UIE_SRC_MODEM] = raw_src[`UIE_SRC_MODEM] && enable_q[`UIE_EN_MODEM];
  assign active_src[`UIE_SRC_PIN] = raw_src[`UIE_SRC_PIN] && enable_q[`UIE_EN_MODEM];
  assign active_src[`UIE_SRC_SWFLOW] = raw_src[`UIE_SRC_SWFLOW] && enable_q[`UIE_EN_SWFLOW];
  assign active_src[`UIE_SRC_CTS] = raw_src[`UIE_SRC_CTS] && enable_q[`UIE_EN_CTS];
  assign active_src[`UIE_SRC_RTS] = raw_src[`UIE_SRC_RTS] && enable_q[`UIE_EN_RTS];

  uie_prio #(
    .NSRC(`UIE_NSRC)
  ) u_prio (
    .active(active_src),
    .pending(pend),
    .code(code)
  );

  // sleep bit only counts when enhanced
  assign sleep_permit = enable_q[`UIE_EN_SLEEP] && enhanced_en;

  uie_sleep u_sleep (
    .mclk(mclk),
    .nrst(nrst),
    .permit(sleep_permit),
    .pending(pend),
    .modem_toggle(modem_toggle),
    .rx_pin(rx_pin),
    .tx_fifo_empty(tx_fifo_empty),
    .rx_fifo_empty(rx_fifo_empty),
    .tx_load(tx_load),
    .asleep(sl_asleep),
    .xtal_en(sl_xtal),
    .uart_clk_en(sl_uclk)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    enable_d = enable_q;
    divisor_d = divisor_q;
    rdata_d = rdata_q;
    if (wr_enable) begin
      enable_d = (reg_wdata & `UIE_EN_LO_MASK) |
                 ((enhanced_en ? reg_wdata : enable_q) & `UIE_EN_HI_MASK);
    end
    if (sw_reset) begin
      enable_d = `UIE_RST_ENABLE;
    end
    if (wr_divisor) begin
      divisor_d = reg_wdata;
    end
    if (reg_rd) begin
      if (hit(reg_addr, `UIE_OFF_ENABLE, divisor_access)) begin
        rdata_d = enable_q;
      end else if (rd_ident) begin
        rdata_d = ident_q;
      end else if ((reg_addr == `UIE_OFF_ENABLE) && divisor_access) begin
        rdata_d = divisor_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // Event flags; a set in the clearing cycle wins
  always_comb begin
    pin_d = pin_q;
    xoff_d = xoff_q;
    spec_d = spec_q;
    cts_d = cts_q;
    rts_d = rts_q;
    // Xon clears Xoff, read clears special
    if (xon_det) begin
      xoff_d = 1'b0;
    end
    if (rd_ident) begin
      spec_d = 1'b0;
      pin_d = 1'b0;
      cts_d = 1'b0;
      rts_d = 1'b0;
    end
    if (sw_reset) begin
      pin_d = 1'b0;
      xoff_d = 1'b0;
      spec_d = 1'b0;
      cts_d = 1'b0;
      rts_d = 1'b0;
    end
    if (pin_change) begin
      pin_d = 1'b1;
    end
    if (xoff_det) begin
      xoff_d = 1'b1;
    end
    if (special_det) begin
      spec_d = 1'b1;
    end
    if (cts_inactive) begin
      cts_d = 1'b1;
    end
    if (rts_inactive) begin
      rts_d = 1'b1;
    end
  end

  always_comb begin
    ident_d = {fifo_en, fifo_en, code[5:1], !pend};
    irq_d = pend;
    asleep_d = sl_asleep;
    xtal_d = sl_xtal;
    uclk_d = sl_uclk;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      enable_q <= `UIE_RST_ENABLE;
      divisor_q <= `UIE_RST_DIVISOR;
      rdata_q <= 8'h00;
      ident_q <= `UIE_RST_IDENT;
      irq_q <= 1'b0;
      pin_q <= 1'b0;
      xoff_q <= 1'b0;
      spec_q <= 1'b0;
      cts_q <= 1'b0;
      rts_q <= 1'b0;
      asleep_q <= 1'b0;
      xtal_q <= 1'b1;
      uclk_q <= 1'b1;
    end else begin
      enable_q <= enable_d;
      divisor_q <= divisor_d;
      rdata_q <= rdata_d;
      ident_q <= ident_d;
      irq_q <= irq_d;
      pin_q <= pin_d;
      xoff_q <= xoff_d;
      spec_q <= spec_d;
      cts_q <= cts_d;
      rts_q <= rts_d;
      asleep_q <= asleep_d;
      xtal_q <= xtal_d;
      uclk_q <= uclk_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign interrupt_enable = enable_q;
  assign baud_divisor_high = divisor_q;
  assign asleep = asleep_q;
  assign xtal_en = xtal_q;
  assign uart_clk_en = uclk_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_upper_write;
    reg_wr && hit(reg_addr, `UIE_OFF_ENABLE, divisor_access) && !enhanced_en && !sw_reset;
  endsequence

  AST_UPPER_LOCKED: assert property (s_upper_write |=>
    (enable_q[7:4] == $past(enable_q[7:4])) && (enable_q[3:0] == $past(reg_wdata[3:0])))
    else $error("upper enable bits changed without enhanced enable");
  AST_DIVISOR_KEPT: assert property (sw_reset && !wr_divisor |=> divisor_q == $past(divisor_q))
    else $error("software reset disturbed divisor");
  AST_PEND_BIT: assert property (##1 ident_q[0] == !$past(pend))
    else $error("identification bit 0 wrong");
  AST_FIFO_MIRROR: assert property (##1 ident_q[7:6] == {2{$past(fifo_en)}})
    else $error("identification bits 7,6 do not mirror FIFO enable");
  AST_LINE_FIRST: assert property (active_src[`UIE_SRC_LINE] |=> ident_q[5:0] == `UIE_ID_LINE)
    else $error("line error not reported first");
  AST_TX_READY: assert property (enable_q[`UIE_EN_THR] && fifo_en && (tx_space > tx_trigger)
    && (active_src[2:0] == 3'h0) |=> ident_q[5:0] == `UIE_ID_THR)
    else $error("transmit ready not reported");
  sequence s_pin_event;
    pin_change && enable_q[`UIE_EN_MODEM] && (active_src[4:0] == 5'h00);
  endsequence

  sequence s_pin_alone;
    enable_q[`UIE_EN_MODEM] && (active_src[4:0] == 5'h00);
  endsequence

  AST_PIN_CODE: assert property (s_pin_event ##1 s_pin_alone |=> ident_q[5:0] == `UIE_ID_PIN)
    else $error("pin change code wrong");
  AST_SWFLOW_CODE: assert property (active_src[`UIE_SRC_SWFLOW] && (active_src[5:0] == 6'h00) |=>
    ident_q[5:0] == `UIE_ID_SWFLOW)
    else $error("software flow code wrong");
  AST_FLOW_CODE: assert property ((active_src[`UIE_SRC_CTS] || active_src[`UIE_SRC_RTS]) &&
    (active_src[6:0] == 7'h00) |=> ident_q[5:0] == `UIE_ID_FLOWCHG)
    else $error("flow input change code wrong");
  AST_SET_WINS: assert property (special_det && rd_ident |=> spec_q)
    else $error("special character event lost on read");
  AST_XON_CLEAR: assert property (xon_det && !xoff_det |=> !xoff_q)
    else $error("Xon did not clear Xoff flag");
  AST_XOFF_KEPT: assert property (xoff_q && rd_ident && !xon_det && !sw_reset |=> xoff_q)
    else $error("identification read cleared Xoff flag");
  AST_DISABLED_QUIET: assert property ((enable_q == 8'h00) ##1 (enable_q == 8'h00) |=> !irq_q)
    else $error("interrupt with all sources disabled");
  AST_NONE_QUIET: assert property (!(|active_src) |=> !irq_q)
    else $error("interrupt without an enabled pending source");
  AST_DLAB_BLOCK: assert property (reg_wr && divisor_access |=> enable_q == $past(enable_q) || $past(sw_reset))
    else $error("enable written with divisor access set");
  AST_CLOCK_STOP: assert property (asleep_q |-> !xtal_q && !uclk_q)
    else $error("clocks running while asleep");
  AST_SLEEP_NEEDS_EN: assert property (!enhanced_en [*2] |=> !asleep_q)
    else $error("asleep without enhanced enable");

endmodule // uie_top

// >>> test/uie_host.sv
// Host model driving the register access port of one channel
`timescale 1ns/10ps
module uie_host (
  // Clock
  input wire logic mclk,
  // Register access
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Line control divisor access bit
  output logic divisor_access
);
  initial begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    divisor_access = 1'b0;
  end

  // Released lines go to the inverse, so a stale value never looks valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask

  task automatic dlab(input logic v);
    @(posedge mclk);
    divisor_access <= v;
    #1;
  endtask
endmodule // uie_host

// >>> test/test_uie_top.sv
// Self-checking bench for interrupt enable, identification and sleep control
`timescale 1ns/10ps
`include "uie_regs.svh"
module test_uie_top;
  logic mclk, nrst, sw_reset, enhanced_en, fifo_en;
  logic [6:0] tx_trigger, tx_space;
  logic [4:0] lvl;
  logic [5:0] ev;
  logic modem_toggle, rx_pin, tx_fifo_empty, rx_fifo_empty;
  logic [3:0] reg_addr;
  logic reg_wr, reg_rd, divisor_access, irq, asleep, xtal_en, uart_clk_en;
  logic [7:0] reg_wdata, reg_rdata, interrupt_enable, baud_divisor_high, rv;
  int errors, n_tests, cycles;
  // Level source codes, index is the lvl bit
  logic [5:0] codes [5] = '{`UIE_ID_MODEM, `UIE_ID_THR, `UIE_ID_RXDATA, `UIE_ID_RXTO, `UIE_ID_LINE};
  logic [7:0] en_tab [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
  logic [7:0] gx_tab [4] = '{8'h0C, 8'h02, 8'h06, 8'h00};
  // Xoff last: its flag survives reads and would mask the later ones
  int ev_tab [5] = '{0, 3, 4, 5, 1};
  logic [7:0] e1_tab [5] = '{8'h30, 8'h10, 8'h20, 8'h20, 8'h10};
  logic [7:0] e2_tab [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h10};

  uie_host host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .divisor_access(divisor_access));

  uie_top dut_u (.mclk(mclk), .nrst(nrst), .sw_reset(sw_reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .divisor_access(divisor_access),
    .enhanced_en(enhanced_en), .fifo_en(fifo_en), .tx_trigger(tx_trigger), .line_error(lvl[4]),
    .rx_timeout(lvl[3]), .rx_data_ready(lvl[2]), .thr_empty(lvl[1]), .tx_space(tx_space),
    .modem_change(lvl[0]), .pin_change(ev[0]), .xoff_det(ev[1]), .xon_det(ev[2]), .special_det(ev[3]),
    .cts_inactive(ev[4]), .rts_inactive(ev[5]), .modem_toggle(modem_toggle), .rx_pin(rx_pin),
    .tx_fifo_empty(tx_fifo_empty), .rx_fifo_empty(rx_fifo_empty), .irq(irq),
    .interrupt_enable(interrupt_enable), .baud_divisor_high(baud_divisor_high), .asleep(asleep),
    .xtal_en(xtal_en), .uart_clk_en(uart_clk_en));

  // ****
  // Checking and closing
  // ****
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Two edges let the registered identification follow its sources
  task automatic ident(input logic [7:0] exp);
    repeat (2) @(posedge mclk);
    host_u.rd(`UIE_OFF_IDENT, rv);
    chk("ident", exp, rv);
  endtask

  task automatic wr_en(input logic [7:0] d);
    host_u.wr(`UIE_OFF_ENABLE, d);
  endtask

  task automatic pulse(input int i);
    @(posedge mclk);
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev[i] <= 1'b0;
  endtask

  task automatic sleep_is(input logic exp);
    for (int i = 0; i < 10 && asleep !== exp; i++) @(posedge mclk);
    @(posedge mclk);
    #1;
    chk("asleep", {7'h00, exp}, {7'h00, asleep});
    chk("xtal_en", {7'h00, ~exp}, {7'h00, xtal_en});
    chk("uart_clk_en", {7'h00, ~exp}, {7'h00, uart_clk_en});
  endtask

  task automatic stop_test;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      stop_test();
    end
  end

  // ****
  // Main sequence
  // ****
  initial begin
    {nrst, sw_reset, enhanced_en, fifo_en, modem_toggle, rx_fifo_empty} = 6'h00;
    {tx_trigger, tx_space, lvl, ev} = '0;
    tx_trigger = 7'h08;
    {rx_pin, tx_fifo_empty} = 2'h3;
    {errors, n_tests, cycles} = '0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    chk("enable", `UIE_RST_ENABLE, interrupt_enable);
    chk("divisor", `UIE_RST_DIVISOR, baud_divisor_high);
    ident(`UIE_RST_IDENT);
    wr_en(8'hFF);
    chk("enable", 8'h0F, interrupt_enable);
    @(posedge mclk) enhanced_en <= 1'b1;
    wr_en(8'hFF);
    chk("enable", 8'hFF, interrupt_enable);
    host_u.rd(`UIE_OFF_ENABLE, rv);
    chk("enable_rd", 8'hFF, rv);
    host_u.dlab(1'b1);
    wr_en(8'hA5);
    chk("divisor", 8'hA5, baud_divisor_high);
    chk("enable", 8'hFF, interrupt_enable);
    host_u.rd(`UIE_OFF_ENABLE, rv);
    chk("divisor_rd", 8'hA5, rv);
    host_u.rd(`UIE_OFF_IDENT, rv);
    chk("ident_hidden", 8'h00, rv);
    host_u.dlab(1'b0);
    @(posedge mclk);
    sw_reset <= 1'b1;
    @(posedge mclk);
    sw_reset <= 1'b0;
    #1;
    chk("enable", 8'h00, interrupt_enable);
    chk("divisor", 8'hA5, baud_divisor_high);
    // Power-on reset in mid-run clears what software reset spared
    @(posedge mclk) nrst <= 1'b0;
    @(posedge mclk) nrst <= 1'b1;
    #1;
    chk("divisor", `UIE_RST_DIVISOR, baud_divisor_high);
    wr_en(8'hEF);
    @(posedge mclk) lvl <= 5'h1F;
    for (int i = 4; i >= 0; i--) begin
      ident({2'b00, codes[i]});
      chk("irq", 8'h01, {7'h00, irq});
      @(posedge mclk) lvl[i] <= 1'b0;
    end
    ident(8'h01);
    @(posedge mclk) lvl <= 5'h1F;
    for (int i = 0; i < 4; i++) begin
      wr_en(en_tab[i]);
      ident(gx_tab[i]);
    end
    wr_en(8'h00);
    ident(8'h01);
    chk("irq", 8'h00, {7'h00, irq});
    @(posedge mclk) {lvl, fifo_en} <= 6'h01;
    wr_en(8'h02);
    @(posedge mclk) tx_space <= 7'h08;
    ident(8'hC1);
    @(posedge mclk) tx_space <= 7'h09;
    ident(8'hC2);
    @(posedge mclk) {tx_space, fifo_en} <= '0;
    wr_en(8'hE8);
    for (int i = 0; i < 5; i++) begin
      pulse(ev_tab[i]);
      ident(e1_tab[i]);
      ident(e2_tab[i]);
    end
    pulse(2);
    ident(8'h01);
    wr_en(8'h08);
    pulse(4);
    ident(8'h01);
    @(posedge mclk) rx_fifo_empty <= 1'b1;
    wr_en(8'h10);
    sleep_is(1'b1);
    @(posedge mclk) rx_pin <= 1'b0;
    sleep_is(1'b0);
    @(posedge mclk) rx_pin <= 1'b1;
    sleep_is(1'b1);
    // Fifo shows the byte before the load lands, else sleep re-enters at once
    @(posedge mclk) tx_fifo_empty <= 1'b0;
    host_u.wr(`UIE_OFF_HOLDING, 8'h55);
    sleep_is(1'b0);
    @(posedge mclk) tx_fifo_empty <= 1'b1;
    sleep_is(1'b1);
    @(posedge mclk) modem_toggle <= 1'b1;
    sleep_is(1'b0);
    @(posedge mclk) modem_toggle <= 1'b0;
    sleep_is(1'b1);
    @(posedge mclk) enhanced_en <= 1'b0;
    sleep_is(1'b0);
    stop_test();
  end
endmodule // test_uie_top
